// >>> core/adcm_cfg_port.sv
// mode configuration port: parallel straps or serial register access
// assumes all pins are asynchronous to clock_i and sck is far slower
//
// What this block does
// RULE1 - strap high makes pins static mode inputs
// RULE2 - parallel: chip select sets duty stabilizer
// RULE3 - parallel: sck picks full cmos or lvds
// RULE4 - parallel: sdi/sdo pair sets power state
// RULE5 - strap low makes pins a serial port
// RULE6 - chip select low to high frames transaction
// RULE7 - sample first sixteen rising sck edges only
// RULE8 - word: rw flag, seven address, eight data
// RULE9 - rw low writes data to address
// RULE10 - rw high shifts register out, no write
// RULE11 - host issues soft reset first after power
// RULE12 - reset bit clears registers, forces sleep briefly
// RULE13 - power register low bits select state
// RULE14 - timing bit3 inverts clock, bit0 stabilizer
// RULE15 - timing bits two:one delay output clock
// RULE16 - host enables stabilizer when delay nonzero
// RULE17 - driver bits six:four set drive current
// RULE18 - driver bit3 termination, doubled current
// RULE19 - driver bit2 puts outputs high impedance
// RULE20 - driver bits one:zero choose interface
// RULE21 - format bits five:three select test pattern
// RULE22 - alternate polarity forces offset binary
// RULE23 - format bit1 scrambles, bit0 two's complement
// RULE24 - scrambler xors upper bits with lsb
// RULE25 - alternate polarity inverts odd data bits
// RULE26 - test pattern overrides all formatting
// RULE27 - writes outside known addresses change nothing
`timescale 1ns/10ps
`default_nettype none
module adcm_cfg_port
  import adcm_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // mode pins
  input  wire logic        interface_select_strap_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        sck_i,
  input  wire logic        sdi_i,
  input  wire logic        sdo_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  // sample path
  input  wire logic        sample_valid_i,
  input  wire logic [15:0] sample_data_i,
  input  wire logic        overrange_flag_i,
  output logic      [15:0] data_o,
  output logic             overrange_flag_o,
  output logic             data_oe_o,
  // mode outputs
  output logic             duty_stabilizer_enable_o,
  output logic      [1:0]  output_interface_field_o,
  output logic      [2:0]  diff_drive_current_field_o,
  output logic             internal_term_enable_o,
  output logic      [1:0]  power_state_field_o,
  output logic             out_clock_invert_o,
  output logic      [1:0]  out_clock_delay_field_o
);

  // rising edge from a synchronised level and its previous copy
  function automatic logic edge_up(input logic prev, input logic cur);
    edge_up = !prev && cur;
  endfunction : edge_up

  // synchronisers, stage one feeds stage two only
  logic strap_s1_reg, strap_s2_reg;
  logic cs_s1_reg,    cs_s2_reg,  cs_prev_reg;
  logic sck_s1_reg,   sck_s2_reg, sck_prev_reg;
  logic sdi_s1_reg,   sdi_s2_reg;
  logic sdo_s1_reg,   sdo_s2_reg;

  // serial engine state
  logic [4:0]  bit_cnt_reg,  bit_cnt_next;  // rising edges taken
  logic [15:0] shift_reg,    shift_next;    // received bits
  logic [7:0]  rd_reg,       rd_next;       // readback shifter
  logic        rd_act_reg,   rd_act_next;   // read data phase
  logic        srst_reg,     srst_next;     // soft reset in force
  logic [7:0]  mode_reg  [1:4];             // mode registers by address
  logic [7:0]  mode_next [1:4];

  // registered outputs
  logic        sdo_oe_reg,   sdo_oe_next;
  logic        duty_reg,     duty_next;
  logic [1:0]  iface_reg,    iface_next;
  logic [2:0]  drive_reg,    drive_next;
  logic        term_reg,     term_next;
  logic [1:0]  power_reg,    power_next;
  logic        inv_reg,      inv_next;
  logic [1:0]  delay_reg,    delay_next;
  logic        oe_reg,       oe_next;

  // decoded events
  logic        serial_mode;  // strap low
  logic        cs_fall;      // frame start
  logic        cs_rise;      // frame end
  logic        sck_rise;
  logic        sck_fall;
  logic [15:0] word;         // shift register with the new bit
  logic [6:0]  addr;         // address of the finished word

  assign serial_mode = !strap_s2_reg; // [RULE1] [RULE5]
  assign cs_fall     = edge_up(cs_s2_reg, cs_prev_reg);
  assign cs_rise     = edge_up(cs_prev_reg, cs_s2_reg);
  assign sck_rise    = edge_up(sck_prev_reg, sck_s2_reg);
  assign sck_fall    = edge_up(sck_s2_reg, sck_prev_reg);
  assign word        = {shift_reg[14:0], sdi_s2_reg};
  assign addr        = word[ADCM_ADDR_MSB:ADCM_ADDR_LSB];

  // two-flop sampling of every pin
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
      cs_s1_reg    <= 1'b1;
      cs_s2_reg    <= 1'b1;
      cs_prev_reg  <= 1'b1;
      sck_s1_reg   <= 1'b0;
      sck_s2_reg   <= 1'b0;
      sck_prev_reg <= 1'b0;
      sdi_s1_reg   <= 1'b0;
      sdi_s2_reg   <= 1'b0;
      sdo_s1_reg   <= 1'b0;
      sdo_s2_reg   <= 1'b0;
    end
    else
    begin
      strap_s1_reg <= interface_select_strap_i;
      strap_s2_reg <= strap_s1_reg;
      cs_s1_reg    <= chip_select_n_i;
      cs_s2_reg    <= cs_s1_reg;
      cs_prev_reg  <= cs_s2_reg;
      sck_s1_reg   <= sck_i;
      sck_s2_reg   <= sck_s1_reg;
      sck_prev_reg <= sck_s2_reg;
      sdi_s1_reg   <= sdi_i;
      sdi_s2_reg   <= sdi_s1_reg;
      sdo_s1_reg   <= sdo_i;
      sdo_s2_reg   <= sdo_s1_reg;
    end
  end

  // serial engine and register writes
  always_comb
  begin
    bit_cnt_next = bit_cnt_reg;
    shift_next   = shift_reg;
    rd_next      = rd_reg;
    rd_act_next  = rd_act_reg;
    srst_next    = srst_reg;
    mode_next    = mode_reg;
    if (!serial_mode)
    begin
      // pins are straps, port idle
      bit_cnt_next = '0;
      rd_act_next  = 1'b0;
      srst_next    = 1'b0;
    end
    else if (cs_fall)
    begin
      bit_cnt_next = '0; // [RULE6]
      rd_act_next  = 1'b0;
    end
    else if (!cs_s2_reg && sck_rise && bit_cnt_reg < ADCM_FRAME_BITS) // [RULE7]
    begin
      shift_next   = word; // [RULE8]
      bit_cnt_next = bit_cnt_reg + 5'h01;
      // header done: load the addressed register for readback
      if (bit_cnt_reg == ADCM_HDR_LAST && word[7])
      begin
        rd_act_next = 1'b1; // [RULE10]
        unique case (word[6:0])
          ADCM_ADDR_SOFT_RESET:   rd_next = ADCM_SOFT_RESET_READ; // [RULE12]
          ADCM_ADDR_POWER_STATE:  rd_next = mode_reg[1];
          ADCM_ADDR_CLOCK_TIMING: rd_next = mode_reg[2];
          ADCM_ADDR_DRIVER_MODE:  rd_next = mode_reg[3];
          ADCM_ADDR_SAMPLE_FMT:   rd_next = mode_reg[4];
          default:                rd_next = ADCM_REG_RESET_VAL;
        endcase
      end
      // sixteenth bit of a write frame
      if (bit_cnt_reg == ADCM_DATA_LAST && !word[ADCM_RW_POS]) // [RULE9]
      begin
        if (addr == ADCM_ADDR_SOFT_RESET)
        begin
          if (word[ADCM_SRST_BIT])
          begin
            srst_next = 1'b1; // [RULE12]
            for (int i = 1; i <= 4; i++)
              mode_next[i] = ADCM_REG_RESET_VAL;
          end
        end
        else if (addr <= ADCM_ADDR_SAMPLE_FMT) // [RULE27]
          mode_next[addr[2:0]] = word[7:0];
      end
    end
    else if (!cs_s2_reg && sck_fall && rd_act_reg && bit_cnt_reg > ADCM_RD_FIRST)
      rd_next = {rd_reg[6:0], 1'b0}; // next data bit after falling edge
    // frame end: reset bit self-clears, readback stops
    if (serial_mode && cs_rise)
    begin
      rd_act_next = 1'b0; // [RULE6]
      srst_next   = 1'b0; // [RULE12]
    end
  end

  // mode outputs from straps or registers
  always_comb
  begin
    sdo_oe_next = 1'b0;
    oe_next     = 1'b1;
    if (!serial_mode)
    begin
      duty_next  = cs_s2_reg; // [RULE2]
      iface_next = sck_s2_reg ? ADCM_IF_LVDS_DDR : ADCM_IF_CMOS_FULL; // [RULE3]
      drive_next = ADCM_DRIVE_3P5MA;
      term_next  = 1'b0;
      power_next = {sdi_s2_reg, sdo_s2_reg}; // [RULE4]
      inv_next   = 1'b0;
      delay_next = 2'h0;
    end
    else
    begin
      // open drain: enable pulls low for a zero bit
      sdo_oe_next = rd_act_next && !cs_s2_reg && !rd_next[7]; // [RULE10]
      duty_next   = mode_next[2][ADCM_DUTY_BIT]; // [RULE14]
      inv_next    = mode_next[2][ADCM_CLK_INV_BIT];
      delay_next  = mode_next[2][2:1]; // [RULE15]
      drive_next  = mode_next[3][6:4]; // [RULE17]
      term_next   = mode_next[3][ADCM_TERM_BIT]; // [RULE18]
      oe_next     = !mode_next[3][ADCM_OUT_DIS_BIT]; // [RULE19]
      iface_next  = mode_next[3][1:0]; // [RULE20]
      // soft reset holds sleep until the frame ends
      power_next  = srst_next ? ADCM_PWR_SLEEP : mode_next[1][1:0]; // [RULE13]
    end
  end

  // register engine state and outputs
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      bit_cnt_reg <= '0;
      shift_reg   <= '0;
      rd_reg      <= '0;
      rd_act_reg  <= 1'b0;
      srst_reg    <= 1'b0;
      for (int i = 1; i <= 4; i++)
        mode_reg[i] <= ADCM_REG_RESET_VAL;
      sdo_oe_reg  <= 1'b0;
      duty_reg    <= 1'b0;
      iface_reg   <= ADCM_IF_CMOS_FULL;
      drive_reg   <= ADCM_DRIVE_3P5MA;
      term_reg    <= 1'b0;
      power_reg   <= ADCM_PWR_NORMAL;
      inv_reg     <= 1'b0;
      delay_reg   <= 2'h0;
      oe_reg      <= 1'b1;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
      rd_reg      <= rd_next;
      rd_act_reg  <= rd_act_next;
      srst_reg    <= srst_next;
      mode_reg    <= mode_next;
      sdo_oe_reg  <= sdo_oe_next;
      duty_reg    <= duty_next;
      iface_reg   <= iface_next;
      drive_reg   <= drive_next;
      term_reg    <= term_next;
      power_reg   <= power_next;
      inv_reg     <= inv_next;
      delay_reg   <= delay_next;
      oe_reg      <= oe_next;
    end
  end

  // format settings to the formatter
  adcm_fmt_if fmt_bus ();
  assign fmt_bus.test_pattern_field   = mode_reg[4][5:3]; // [RULE21]
  assign fmt_bus.alt_polarity_enable  = mode_reg[4][ADCM_ALT_POL_BIT];
  assign fmt_bus.scramble_enable      = mode_reg[4][ADCM_SCRAMBLE_BIT];
  assign fmt_bus.signed_format_select = mode_reg[4][ADCM_SIGNED_BIT];

  adcm_fmt u_fmt (
    .clock_i          (clock_i),
    .reset_n_i        (reset_n_i),
    .cfg              (fmt_bus.fmt),
    .sample_valid_i   (sample_valid_i),
    .sample_data_i    (sample_data_i),
    .overrange_flag_i (overrange_flag_i),
    .data_o           (data_o),
    .overrange_flag_o (overrange_flag_o)
  );

  // pin and mode outputs
  assign sdo_o                      = 1'b0;
  assign sdo_oe_o                   = sdo_oe_reg;
  assign data_oe_o                  = oe_reg;
  assign duty_stabilizer_enable_o   = duty_reg;
  assign output_interface_field_o   = iface_reg;
  assign diff_drive_current_field_o = drive_reg;
  assign internal_term_enable_o     = term_reg;
  assign power_state_field_o        = power_reg;
  assign out_clock_invert_o         = inv_reg;
  assign out_clock_delay_field_o    = delay_reg;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  a_par_duty: assert property (!serial_mode |=> // [RULE2]
    duty_stabilizer_enable_o == $past(cs_s2_reg))
    else $error("parallel duty stabilizer mismatch");
  a_par_iface: assert property (!serial_mode |=> // [RULE3]
    output_interface_field_o == ($past(sck_s2_reg) ? 2'h1 : 2'h0)
    && diff_drive_current_field_o == 3'h0 && !internal_term_enable_o)
    else $error("parallel output mode mismatch");
  a_par_power: assert property (!serial_mode |=> // [RULE4]
    power_state_field_o == $past({sdi_s2_reg, sdo_s2_reg}) && !sdo_oe_o)
    else $error("parallel power state mismatch");
  a_frame_start: assert property (serial_mode && cs_fall |=> // [RULE6]
    bit_cnt_reg == 5'h00 && !rd_act_reg)
    else $error("frame start did not clear count");
  a_edge_limit: assert property (bit_cnt_reg == 5'h10 && !cs_fall // [RULE7]
    && serial_mode |=> bit_cnt_reg == 5'h10 && $stable(shift_reg))
    else $error("edge after sixteenth was taken");
  a_write_store: assert property (serial_mode && !cs_s2_reg && sck_rise // [RULE9]
    && bit_cnt_reg == 5'h0F && !word[15] && addr == 7'h02
    |=> mode_reg[2] == $past(word[7:0]) ##1 out_clock_invert_o
        == mode_reg[2][3])
    else $error("write to timing register lost");
  a_read_hold: assert property (rd_act_reg |-> // [RULE10]
    $stable(mode_reg[1]) && $stable(mode_reg[3]) && $stable(mode_reg[4]))
    else $error("register changed during readback");
  a_srst_sleep: assert property ($rose(srst_reg) |-> // [RULE12]
    power_state_field_o == 2'h3 && mode_reg[1] == 8'h00
    && mode_reg[4] == 8'h00)
    else $error("soft reset did not clear and sleep");
  a_unmapped: assert property (serial_mode && !cs_s2_reg && sck_rise // [RULE27]
    && bit_cnt_reg == 5'h0F && !word[15] && addr > 7'h04
    |=> $stable(mode_reg[1]) && $stable(mode_reg[2])
        && $stable(mode_reg[3]) && $stable(mode_reg[4]))
    else $error("unmapped write changed a register");

  c_write: cover property (serial_mode && bit_cnt_reg == 5'h0F && sck_rise
    && !word[15]);
  c_read: cover property ($rose(rd_act_reg) ##[1:300] sdo_oe_o);
  c_srst: cover property ($rose(srst_reg));
  c_parallel: cover property (!serial_mode && power_state_field_o == 2'h2);

endmodule : adcm_cfg_port
`default_nettype wire

// >>> include/adcm_pkg.sv
// constants shared by the converter mode configuration port
// assumes a single 40 MHz core clock samples every pin
package adcm_pkg;

  // serial frame shape
  localparam logic [4:0] ADCM_FRAME_BITS = 5'h10; // bits taken per frame
  localparam logic [4:0] ADCM_HDR_LAST   = 5'h07; // count before last hdr bit
  localparam logic [4:0] ADCM_DATA_LAST  = 5'h0F; // count before last bit
  localparam logic [4:0] ADCM_RD_FIRST   = 5'h08; // first count of read data
  localparam int         ADCM_RW_POS     = 15;    // read/write flag position
  localparam int         ADCM_ADDR_MSB   = 14;    // address field top
  localparam int         ADCM_ADDR_LSB   = 8;     // address field bottom

  // register addresses
  localparam logic [6:0] ADCM_ADDR_SOFT_RESET   = 7'h00;
  localparam logic [6:0] ADCM_ADDR_POWER_STATE  = 7'h01;
  localparam logic [6:0] ADCM_ADDR_CLOCK_TIMING = 7'h02;
  localparam logic [6:0] ADCM_ADDR_DRIVER_MODE  = 7'h03;
  localparam logic [6:0] ADCM_ADDR_SAMPLE_FMT   = 7'h04;
  localparam logic [7:0] ADCM_REG_RESET_VAL     = 8'h00;
  localparam logic [7:0] ADCM_SOFT_RESET_READ   = 8'h00; // value is arbitrary

  // field positions
  localparam int ADCM_SRST_BIT      = 7; // soft reset request
  localparam int ADCM_CLK_INV_BIT   = 3; // out_clock_invert
  localparam int ADCM_DUTY_BIT      = 0; // duty_stabilizer_enable
  localparam int ADCM_TERM_BIT      = 3; // internal_term_enable
  localparam int ADCM_OUT_DIS_BIT   = 2; // output_disable
  localparam int ADCM_ALT_POL_BIT   = 2; // alt_polarity_enable
  localparam int ADCM_SCRAMBLE_BIT  = 1; // scramble_enable
  localparam int ADCM_SIGNED_BIT    = 0; // signed_format_select

  // power states
  localparam logic [1:0] ADCM_PWR_NORMAL = 2'h0;
  localparam logic [1:0] ADCM_PWR_NAP    = 2'h2;
  localparam logic [1:0] ADCM_PWR_SLEEP  = 2'h3;

  // output interface codes
  localparam logic [1:0] ADCM_IF_CMOS_FULL = 2'h0;
  localparam logic [1:0] ADCM_IF_LVDS_DDR  = 2'h1;
  localparam logic [2:0] ADCM_DRIVE_3P5MA  = 3'h0; // default drive code

  // test pattern codes
  localparam logic [2:0] ADCM_TP_OFF     = 3'h0;
  localparam logic [2:0] ADCM_TP_ZEROS   = 3'h1;
  localparam logic [2:0] ADCM_TP_ONES    = 3'h3;
  localparam logic [2:0] ADCM_TP_CHECKER = 3'h5;
  localparam logic [2:0] ADCM_TP_ALTERN  = 3'h7;
  localparam logic [15:0] ADCM_ODD_MASK   = 16'hAAAA; // odd data bits
  localparam logic [15:0] ADCM_CHECK_WORD = 16'h5555; // checker phase 0

endpackage : adcm_pkg

// >>> include/adcm_fmt_if.sv
// format settings passed from the register bank to the sample formatter
// assumes both ends run on the core clock
`timescale 1ns/10ps
`default_nettype none
interface adcm_fmt_if;
  logic [2:0] test_pattern_field;  // test pattern select
  logic       alt_polarity_enable; // invert odd bits
  logic       scramble_enable;     // xor with lsb
  logic       signed_format_select; // two's complement
  modport cfg (output test_pattern_field, alt_polarity_enable,
               scramble_enable, signed_format_select);
  modport fmt (input test_pattern_field, alt_polarity_enable,
               scramble_enable, signed_format_select);
endinterface : adcm_fmt_if
`default_nettype wire

// >>> core/adcm_fmt.sv
// sample formatter: test patterns, two's complement, scrambler, polarity
// assumes offset binary samples with a one-cycle valid on the core clock
`timescale 1ns/10ps
`default_nettype none
module adcm_fmt
  import adcm_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // settings
  adcm_fmt_if.fmt          cfg,
  // sample in
  input  wire logic        sample_valid_i,
  input  wire logic [15:0] sample_data_i,
  input  wire logic        overrange_flag_i,
  // sample out
  output logic      [15:0] data_o,
  output logic             overrange_flag_o
);

  logic [15:0] data_reg,  data_next;   // formatted word
  logic        of_reg,    of_next;     // formatted overrange flag
  logic        phase_reg, phase_next;  // alternates per sample
  logic [15:0] word;                   // working value

  // next sample word
  always_comb
  begin
    data_next  = data_reg;
    of_next    = of_reg;
    phase_next = phase_reg;
    word       = sample_data_i;
    if (sample_valid_i)
    begin
      phase_next = ~phase_reg;
      // signed form only without alternate polarity
      if (cfg.signed_format_select && !cfg.alt_polarity_enable) // [RULE22]
        word[15] = ~word[15]; // [RULE23]
      if (cfg.scramble_enable)
        word[15:1] = word[15:1] ^ {15{word[0]}}; // [RULE24]
      if (cfg.alt_polarity_enable)
        word = word ^ ADCM_ODD_MASK; // [RULE25]
      data_next = word;
      of_next   = overrange_flag_i;
      // pattern overrides all formatting
      unique case (cfg.test_pattern_field) // [RULE26]
        ADCM_TP_ZEROS:
        begin
          data_next = '0; // [RULE21]
          of_next   = 1'b0;
        end
        ADCM_TP_ONES:
        begin
          data_next = '1;
          of_next   = 1'b1;
        end
        ADCM_TP_CHECKER:
        begin
          data_next = phase_reg ? ~ADCM_CHECK_WORD : ADCM_CHECK_WORD;
          of_next   = ~phase_reg;
        end
        ADCM_TP_ALTERN:
        begin
          data_next = {16{phase_reg}};
          of_next   = phase_reg;
        end
        default: ; // off and unused codes pass formatted data
      endcase
    end
  end

  // register the sample
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      data_reg  <= '0;
      of_reg    <= 1'b0;
      phase_reg <= 1'b0;
    end
    else
    begin
      data_reg  <= data_next;
      of_reg    <= of_next;
      phase_reg <= phase_next;
    end
  end

  assign data_o           = data_reg;
  assign overrange_flag_o = of_reg;

  // a pattern of all ones wins over every format bit
  a_pattern_ones: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    sample_valid_i && cfg.test_pattern_field == ADCM_TP_ONES
    |=> data_o == 16'hFFFF && overrange_flag_o) // [RULE26]
    else $error("ones pattern not forced");

  // scrambler leaves the lsb and flag untouched
  a_scramble_lsb: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    sample_valid_i && cfg.test_pattern_field == ADCM_TP_OFF
    && !cfg.alt_polarity_enable
    |=> data_o[0] == $past(sample_data_i[0])
        && overrange_flag_o == $past(overrange_flag_i)) // [RULE24]
    else $error("scrambler touched lsb or flag");

endmodule : adcm_fmt
`default_nettype wire

// >>> testbench/adcm_host_model.sv
// serial host and strap model driving the mode pins of the port
// assumes clock_i is the core clock and sdo_i is the pulled-up wire
`timescale 1ns/10ps
`default_nettype none
module adcm_host_model (
  // core clock and sdo wire
  input  wire logic clock_i,
  input  wire logic sdo_i,
  // mode pins
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      sdi_o
);
  // idle: deselected, sck parked low
  initial
  begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    sdi_o  = 1'b0;
  end
  // n bits from w[16] down; sck low 125 ns, high 75 ns
  task automatic xfer(input logic [16:0] w, input int n,
                      output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clock_i);
    #1 cs_n_o = 1'b0; // frame opens
    for (int i = 16; i > 16 - n; i--)
    begin
      sdi_o = w[i]; // rw, address, data, msb first
      #125 sck_o = 1'b1;
      if (i < 9) rd = {rd[6:0], sdo_i};
      #75 sck_o = 1'b0;
    end
    #100 cs_n_o = 1'b1; // frame closes
    sdi_o = ~sdi_o; // released line no longer shows last bit
    #100;
  endtask : xfer
  // static strap levels: chip select, sck, sdi
  task automatic set_pins(input logic [2:0] v);
    cs_n_o = v[2];
    sck_o  = v[1];
    sdi_o  = v[0];
  endtask : set_pins
endmodule : adcm_host_model
`default_nettype wire

// >>> testbench/test_adcm_cfg_port.sv
// self-checking bench for the converter mode configuration port
// assumes the host model is compiled first; 25 ns core clock
`timescale 1ns/10ps
`default_nettype none
module test_adcm_cfg_port
  import adcm_pkg::*;
;
  logic        clock_i, reset_n_i, strap, par_sdo, valid, of_in, slept;
  logic        cs_n, sck, sdi, sdo_oe, of_o, data_oe, duty, term, inv;
  logic [1:0]  iface, pwr, dly;
  logic [2:0]  drv;
  logic [7:0]  r;
  logic [15:0] sdata, data;
  int          bad_count, num_checks, nsamp;
  int          cyc = 0;
  // open-drain sdo with pull-up; an input pin in strap mode
  wire logic        sdo_w = sdo_oe ? 1'b0 : (strap ? par_sdo : 1'b1);
  wire logic [13:0] mode  = {sdo_oe, data_oe, duty, iface, drv, term,
                             pwr, inv, dly};
  adcm_host_model adcm_host_model_i (.clock_i(clock_i), .sdo_i(sdo_w),
    .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));
  adcm_cfg_port adcm_cfg_port_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .interface_select_strap_i(strap), .chip_select_n_i(cs_n),
    .sck_i(sck), .sdi_i(sdi), .sdo_i(sdo_w), .sdo_o(), .sdo_oe_o(sdo_oe),
    .sample_valid_i(valid), .sample_data_i(sdata),
    .overrange_flag_i(of_in), .data_o(data), .overrange_flag_o(of_o),
    .data_oe_o(data_oe), .duty_stabilizer_enable_o(duty),
    .output_interface_field_o(iface), .diff_drive_current_field_o(drv),
    .internal_term_enable_o(term), .power_state_field_o(pwr),
    .out_clock_invert_o(inv), .out_clock_delay_field_o(dly));
  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // cycle ceiling and forced-sleep watcher
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (!cs_n && pwr === 2'h3) slept <= 1'b1;
    if (cyc == 20000)
    begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // mode pins expected from power, timing and driver registers
  function automatic logic [15:0] em(logic [7:0] p, t, d);
    return {3'h0, ~d[2], t[0], d[1:0], d[6:4], d[3], p[1:0], t[3], t[2:1]};
  endfunction : em
  task automatic chkm(input logic [7:0] p, t, d);
    chk({2'h0, mode}, em(p, t, d), "mode pins");
  endtask : chkm
  task automatic wr(input logic [6:0] a, input logic [7:0] d,
                    input int n = 16);
    adcm_host_model_i.xfer({1'b0, a, d, 1'b1}, n, r);
  endtask : wr
  // read frame carries ones on sdi, which must be ignored
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    adcm_host_model_i.xfer({1'b1, a, 8'hFF, 1'b0}, 16, r);
    chk({8'h00, r}, {8'h00, e}, "readback");
  endtask : rd
  task automatic t_start();
    chk(data, 16'h0000, "data at reset");
    chkm(8'h00, 8'h00, 8'h00);
    wr(ADCM_ADDR_SOFT_RESET, 8'h80);
    chkm(8'h00, 8'h00, 8'h00);
  endtask : t_start
  // every drive current code, power state and clock delay
  task automatic t_regs();
    logic [7:0] p, t, d;
    for (int k = 0; k < 8; k++)
    begin
      p = {6'h00, k[1:0]};
      t = {4'h0, k[2], k[1:0], |k[2:0]}; // stabilizer with delay
      d = {1'b0, k[2:0], k[0], k[1], k[1:0]};
      wr(ADCM_ADDR_POWER_STATE, p);
      wr(ADCM_ADDR_CLOCK_TIMING, t);
      wr(ADCM_ADDR_DRIVER_MODE, d);
      rd(ADCM_ADDR_POWER_STATE, p);
      rd(ADCM_ADDR_CLOCK_TIMING, t);
      rd(ADCM_ADDR_DRIVER_MODE, d);
      chkm(p, t, d);
    end
  endtask : t_regs
  // unmapped writes, a short frame and a frame with one edge too many
  task automatic t_refuse();
    wr(7'h05, 8'hFF);
    wr(7'h7F, 8'hFF);
    rd(7'h05, 8'h00);
    wr(ADCM_ADDR_POWER_STATE, 8'h01, 15);
    chkm(8'h03, 8'h0F, 8'h7F);
    wr(ADCM_ADDR_POWER_STATE, 8'h02, 17);
    chkm(8'h02, 8'h0F, 8'h7F);
  endtask : t_refuse
  task automatic t_soft();
    slept = 1'b0;
    wr(ADCM_ADDR_SOFT_RESET, 8'h80);
    chk({15'h0, slept}, 16'h0001, "sleep forced");
    chkm(8'h00, 8'h00, 8'h00);
    wr(ADCM_ADDR_POWER_STATE, 8'h02); // bit no longer pending
    chkm(8'h02, 8'h00, 8'h00);
  endtask : t_soft
  // one sample through the formatter; e holds flag then data
  task automatic samp(input logic [7:0] f, input logic [15:0] s,
                      input logic [16:0] e);
    wr(ADCM_ADDR_SAMPLE_FMT, f);
    @(posedge clock_i);
    #1 valid = 1'b1;
    sdata = s;
    of_in = ~s[15];
    @(posedge clock_i);
    #1 valid = 1'b0; // one-cycle valid: a single sample per call
    nsamp++;
    chk(data, e[15:0], "sample data");
    chk({15'h0, of_o}, {15'h0, e[16]}, "sample flag");
  endtask : samp
  task automatic t_fmt();
    samp(8'h00, 16'h8001, {1'b0, 16'h8001});
    samp(8'h01, 16'h8001, {1'b0, 16'h0001});
    samp(8'h02, 16'h8001, {1'b0, 16'h7FFF});
    samp(8'h04, 16'h8001, {1'b0, 16'h2AAB});
    samp(8'h05, 16'h8001, {1'b0, 16'h2AAB});
    samp(8'h17, 16'h8001, {1'b0, 16'hD555});
    samp(8'h0F, 16'h0000, {1'b0, 16'h0000});
    samp(8'h1F, 16'h0000, {1'b1, 16'hFFFF});
    repeat (2)
    begin
      samp(8'h2F, 16'h8001, nsamp[0] ? {1'b0, 16'hAAAA} : {1'b1, 16'h5555});
      samp(8'h3F, 16'h8001, nsamp[0] ? {1'b1, 16'hFFFF} : {1'b0, 16'h0000});
    end
  endtask : t_fmt
  // all sixteen strap level combinations
  task automatic t_par();
    strap = 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      adcm_host_model_i.set_pins(k[3:1]);
      par_sdo = k[0];
      repeat (5) @(posedge clock_i);
      #1 chkm({6'h00, k[1:0]}, {7'h00, k[3]}, {7'h00, k[2]});
    end
  endtask : t_par
  initial
  begin
    reset_n_i = 1'b0;
    strap = 1'b0;
    par_sdo = 1'b1;
    valid = 1'b0;
    sdata = 16'h0000;
    of_in = 1'b0;
    repeat (10) @(posedge clock_i);
    #1 reset_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    t_start();
    t_regs();
    t_refuse();
    t_soft();
    t_fmt();
    t_par();
    summarize();
  end
endmodule : test_adcm_cfg_port
`default_nettype wire
